/* cmps_ctrl_pin_select.sv */
// Control-mode pin select: strap decode and serial register port
`timescale 1ns/10ps
module cmps_ctrl_pin_select
	import cmps_pkg::*;
#(
	parameter int STABLE_CYCLES = CMPS_STABLE_CYCLES
) (
	input  wire logic                       sys_clk,
	input  wire logic                       arst_n,
	input  wire logic                       clk_en,
	input  wire logic                       serial_clk,
	input  wire logic [CMPS_NUM_PINS-1:0]   pin_above_hi,
	input  wire logic [CMPS_NUM_PINS-1:0]   pin_below_lo,
	input  wire logic                       serial_data_line,
	input  wire logic                       serial_select_n,
	output cmps_cfg_t                       cfg,
	output logic                            straps_valid,
	output logic                            serial_active,
	output logic                            regs_all_written,
	output logic                            first_write_ok,
	output logic [CMPS_NUM_REGS-1:0][CMPS_DATA_W-1:0] user_regs
);

	// ****************************************
	// Reset release
	// ****************************************
	logic [1:0] rst_sync;
	wire        rst_n = rst_sync[1];

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end

	// ****************************************
	// Strap resolution
	// ****************************************
	cmps_level_t             lvl   [CMPS_NUM_PINS];
	logic [CMPS_NUM_PINS-1:0] lvl_ok;

	genvar gi;
	generate
		for (gi = 0; gi < CMPS_NUM_PINS; gi++) begin : g_pin
			cmps_level_resolve #(
				.STABLE_CYCLES (STABLE_CYCLES)
			) u_res (
				.sys_clk  (sys_clk),
				.rst_n    (rst_n),
				.clk_en   (clk_en),
				.above_hi (pin_above_hi[gi]),
				.below_lo (pin_below_lo[gi]),
				.level    (lvl[gi]),
				.valid    (lvl_ok[gi])
			);
		end
	endgenerate

	// Decode of the settled levels
	wire all_ok    = &lvl_ok;
	wire ext_mode  = (lvl[CMPS_PIN_MODE] == CMPS_LVL_FLOAT);
	wire rng_hi    = (lvl[CMPS_PIN_MODE] == CMPS_LVL_HIGH);
	wire swg_hi    = !ext_mode && (lvl[CMPS_PIN_SWING] == CMPS_LVL_HIGH);
	wire edg_pos   = !ext_mode && (lvl[CMPS_PIN_EDGE] == CMPS_LVL_HIGH);
	wire edg_ddr   = !ext_mode && (lvl[CMPS_PIN_EDGE] == CMPS_LVL_FLOAT);
	wire cal_long  = !ext_mode && (lvl[CMPS_PIN_CALIBRATION_DELAY_SELECT] == CMPS_LVL_HIGH);

	// ****************************************
	// Configuration outputs
	// ****************************************
	// Held at the safe strap meaning until every pin has settled once
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg           <= '0;
			straps_valid  <= 1'b0;
			serial_active <= 1'b0;
		end else if (clk_en && all_ok) begin
			cfg.extended_mode  <= ext_mode;
			cfg.range_high     <= rng_hi;
			cfg.swing_high     <= swg_hi;
			cfg.edge_pos       <= edg_pos;
			cfg.ddr_mode       <= edg_ddr;
			cfg.cal_delay_long <= cal_long;
			straps_valid       <= 1'b1;
			serial_active      <= ext_mode;
		end
	end

	// ****************************************
	// Serial link, serial clock domain
	// ****************************************
	localparam int BCW = $clog2(CMPS_FRAME_BITS + 1);
	localparam logic [BCW-1:0] BIT_LAST = BCW'(CMPS_FRAME_BITS - 1);

	logic [BCW-1:0]             bit_cnt;
	logic [CMPS_FRAME_BITS-2:0] shift;
	cmps_wr_t                   link_word;
	logic                       link_tgl;
	wire                        frame_rst_n = arst_n && !serial_select_n;
	wire [CMPS_FRAME_BITS-1:0]  frame_full  = {shift, serial_data_line};

	// Deselect clears the bit count without a clock edge, since the
	// serial clock may stop as soon as the frame ends
	always_ff @(posedge serial_clk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			bit_cnt <= '0;
			shift   <= '0;
		end else begin
			shift <= frame_full[CMPS_FRAME_BITS-2:0];
			if (bit_cnt != BCW'(CMPS_FRAME_BITS))
				bit_cnt <= bit_cnt + BCW'(1);
		end
	end

	// Completed word is held until the next full frame; extra bits ignored
	always_ff @(posedge serial_clk or negedge arst_n) begin
		if (!arst_n) begin
			link_word <= '0;
			link_tgl  <= 1'b0;
		end else if (!serial_select_n && bit_cnt == BIT_LAST) begin
			link_word.addr <= frame_full[CMPS_DATA_W +: CMPS_ADDR_W];
			link_word.data <= frame_full[CMPS_DATA_W-1:0];
			link_tgl       <= !link_tgl;
		end
	end

	// ****************************************
	// Word crossing into system clock
	// ****************************************
	logic [2:0] tgl_sync;
	cmps_wr_t   wr_q;
	logic       wr_evt;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tgl_sync <= 3'b000;
			wr_q     <= '0;
			wr_evt   <= 1'b0;
		end else if (clk_en) begin
			tgl_sync <= {tgl_sync[1:0], link_tgl};
			wr_evt   <= tgl_sync[2] ^ tgl_sync[1];
			if (tgl_sync[2] ^ tgl_sync[1])
				wr_q <= link_word; // word settled two edges before toggle seen
		end
	end

	// ****************************************
	// User registers
	// ****************************************
	function automatic logic [CMPS_NUM_REGS-1:0] reg_hit(input logic [CMPS_ADDR_W-1:0] a);
		logic [CMPS_NUM_REGS-1:0] h;
		h = '0;
		for (int i = 0; i < CMPS_NUM_REGS; i++)
			h[i] = (CMPS_REG_OFF[i] == a);
		return h;
	endfunction

	logic [CMPS_NUM_REGS-1:0] written;
	wire                      wr_ok  = wr_evt && serial_active;
	wire [CMPS_NUM_REGS-1:0]  hit    = reg_hit(wr_q.addr);
	wire                      dh_hit = (wr_q.addr == CMPS_OFF_FIRST_WRITTEN_CONFIG);
	wire                      dh_new = wr_ok && dh_hit && !(|(written & reg_hit(CMPS_OFF_FIRST_WRITTEN_CONFIG)));

	// Writes only count while the serial port is live
	generate
		for (gi = 0; gi < CMPS_NUM_REGS; gi++) begin : g_reg
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					user_regs[gi] <= CMPS_REG_RESET;
					written[gi]   <= 1'b0;
				end else if (clk_en && wr_ok && hit[gi]) begin
					user_regs[gi] <= wr_q.data;
					written[gi]   <= 1'b1;
				end
			end
		end
	endgenerate

	// Status of the host's loading sequence; the device only reports it
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			regs_all_written <= 1'b0;
			first_write_ok   <= 1'b0;
		end else if (clk_en) begin
			regs_all_written <= &written;
			if (dh_new)
				first_write_ok <= (wr_q.data == CMPS_FIRST_WRITTEN_DEFAULT);
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	ext_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && all_ok && lvl[CMPS_PIN_MODE] == CMPS_LVL_FLOAT |=> cfg.extended_mode && serial_active)
		else $error("floating mode pin did not select extended mode");

	range_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && all_ok && lvl[CMPS_PIN_MODE] != CMPS_LVL_FLOAT
		|=> !cfg.extended_mode && (cfg.range_high == $past(lvl[CMPS_PIN_MODE] == CMPS_LVL_HIGH)))
		else $error("input range does not follow mode pin");

	strap_only_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wr_evt && !serial_active |=> $stable(user_regs) && $stable(written))
		else $error("register changed outside extended mode");

	swing_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && all_ok && !ext_mode ##1 1 |-> cfg.swing_high == $past(lvl[CMPS_PIN_SWING] == CMPS_LVL_HIGH))
		else $error("output swing does not follow swing pin");

	edge_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && all_ok && !ext_mode && lvl[CMPS_PIN_EDGE] == CMPS_LVL_LOW |=> !cfg.edge_pos && !cfg.ddr_mode)
		else $error("low edge pin did not select negative edge");

	ddr_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cfg.ddr_mode |-> !cfg.edge_pos && !cfg.extended_mode)
		else $error("edge select active in double-data-rate mode");

	cal_dly_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && all_ok && !ext_mode && lvl[CMPS_PIN_CALIBRATION_DELAY_SELECT] == CMPS_LVL_HIGH |=> cfg.cal_delay_long)
		else $error("high calibration pin did not select long delay");

	serial_pins_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cfg.extended_mode |-> !cfg.swing_high && !cfg.edge_pos && !cfg.ddr_mode && !cfg.cal_delay_long)
		else $error("strap meaning kept on serial pins");

	first_dh_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && dh_new && wr_q.data != CMPS_FIRST_WRITTEN_DEFAULT |=> !first_write_ok)
		else $error("bad first write reported as good");

endmodule

/* cmps_pkg.sv */
// Constants, types and field layout shared by the control-mode pin select block
// Operation
// - Floating mode pin selects extended serial mode
// - Driven mode pin: low 650, high 870 mV range
// - Non-extended: serial port off, pins only
// - Swing pin driven: low 0.51, high 0.71 V
// - Edge pin low negative edge, high positive
// - Floating edge pin gives double-data-rate clock
// - Calibration pin low short, high long delay
// - Extended mode: pins become clock, data, select
package cmps_pkg;

	// ****************************************
	// Pins and timing
	// ****************************************
	localparam int CMPS_NUM_PINS      = 4;
	localparam int CMPS_PIN_SWING     = 0;
	localparam int CMPS_PIN_EDGE      = 1;
	localparam int CMPS_PIN_CALIBRATION_DELAY_SELECT    = 2;
	localparam int CMPS_PIN_MODE      = 3;
	localparam int CMPS_STABLE_CYCLES = 4;

	// ****************************************
	// Serial frame and registers
	// ****************************************
	localparam int CMPS_ADDR_W     = 4;
	localparam int CMPS_DATA_W     = 16;
	localparam int CMPS_HDR_W      = 8;
	localparam int CMPS_FRAME_BITS = CMPS_HDR_W + CMPS_DATA_W;
	localparam int CMPS_NUM_REGS   = 8;
	localparam logic [CMPS_ADDR_W-1:0] CMPS_OFF_FIRST_WRITTEN_CONFIG = 4'hd;
	localparam logic [CMPS_DATA_W-1:0] CMPS_FIRST_WRITTEN_DEFAULT    = 16'h3fff;
	localparam logic [CMPS_DATA_W-1:0] CMPS_REG_RESET                = 16'h0000;
	localparam logic [CMPS_ADDR_W-1:0] CMPS_REG_OFF [CMPS_NUM_REGS] = '{
		4'h1, 4'h2, 4'h3, 4'h9, 4'ha, 4'hd, 4'he, 4'hf};

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {CMPS_LVL_LOW, CMPS_LVL_HIGH, CMPS_LVL_FLOAT} cmps_level_t;

	typedef struct packed {
		logic extended_mode;
		logic range_high;
		logic swing_high;
		logic edge_pos;
		logic ddr_mode;
		logic cal_delay_long;
	} cmps_cfg_t;

	typedef struct packed {
		logic [CMPS_ADDR_W-1:0] addr;
		logic [CMPS_DATA_W-1:0] data;
	} cmps_wr_t;

endpackage

/* cmps_level_resolve.sv */
// Three-level strap pin resolver with synchroniser and stability filter
`timescale 1ns/10ps
module cmps_level_resolve
	import cmps_pkg::*;
#(
	parameter int STABLE_CYCLES = CMPS_STABLE_CYCLES
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	input  wire logic        above_hi,
	input  wire logic        below_lo,
	output cmps_level_t      level,
	output logic             valid
);
	localparam int CW = $clog2(STABLE_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(STABLE_CYCLES - 1);

	logic [1:0]   hi_sync;
	logic [1:0]   lo_sync;
	logic [CW-1:0] cnt;
	cmps_level_t  cand;
	cmps_level_t  cand_q;
	wire          cand_moved;
	wire          commit;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hi_sync <= 2'b00;
			lo_sync <= 2'b00;
		end else if (clk_en) begin
			hi_sync <= {hi_sync[0], above_hi};
			lo_sync <= {lo_sync[0], below_lo};
		end
	end

	// Neither comparator tripped means nothing drives the pad
	always_comb begin
		if (hi_sync[1] && !lo_sync[1])
			cand = CMPS_LVL_HIGH;
		else if (lo_sync[1] && !hi_sync[1])
			cand = CMPS_LVL_LOW;
		else
			cand = CMPS_LVL_FLOAT;
	end

	assign cand_moved = (cand != cand_q);
	assign commit     = !cand_moved && (cnt == LAST);

	// ****************************************
	// Stability filter
	// ****************************************
	// A pad passing through mid-rail while switching briefly looks floating;
	// the filter keeps that glitch out of the mode decode
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cand_q <= CMPS_LVL_FLOAT;
			cnt    <= '0;
			level  <= CMPS_LVL_FLOAT;
			valid  <= 1'b0;
		end else if (clk_en) begin
			cand_q <= cand;
			if (cand_moved)
				cnt <= '0;
			else if (cnt != LAST)
				cnt <= cnt + CW'(1);
			if (commit) begin
				level <= cand_q;
				valid <= 1'b1;
			end
		end
	end

	strap_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(level != $past(level)) |-> ($past(cnt) == LAST && $past(cand_q) == level))
		else $error("strap level changed before filter settled");

endmodule

/* cmps_host_model.sv */
// Host model driving the strap pads and the three-wire serial port
`timescale 1ns/10ps
module cmps_host_model
	import cmps_pkg::*;
(
	input  wire logic [CMPS_NUM_PINS-1:0][1:0] pad_lvl,
	output logic [CMPS_NUM_PINS-1:0]           pin_above_hi,
	output logic [CMPS_NUM_PINS-1:0]           pin_below_lo,
	output logic                               serial_clk,
	output logic                               serial_data_line,
	output logic                               serial_select_n
);
	// ****************************************
	// Pads
	// ****************************************
	// A floating pad trips neither comparator
	always_comb begin
		for (int i = 0; i < CMPS_NUM_PINS; i++) begin
			pin_above_hi[i] = (pad_lvl[i] == CMPS_LVL_HIGH);
			pin_below_lo[i] = (pad_lvl[i] == CMPS_LVL_LOW);
		end
	end

	// ****************************************
	// Serial port
	// ****************************************
	// Link clock stands still between frames
	initial begin
		serial_clk = 1'b0;
		serial_data_line = 1'b0;
		serial_select_n = 1'b1;
	end

	// Msb first, data moved after the falling edge; a short count cuts the frame
	task automatic send(input logic [23:0] w, input int nbits);
		#7;
		serial_select_n = 1'b0;
		for (int i = 23; i > 23 - nbits; i--) begin
			serial_data_line = w[i];
			#15 serial_clk = 1'b1;
			#15 serial_clk = 1'b0;
		end
		#15 serial_select_n = 1'b1;
		serial_data_line = ~serial_data_line; // Released line must not keep last bit
	endtask
endmodule

/* tb_top.sv */
// Self-checking bench for the control-mode pin select block
`timescale 1ns/10ps
module tb_top
	import cmps_pkg::*;
;
	localparam int STB = 2;
	logic                                     sys_clk;
	logic                                     arst_n;
	logic                                     clk_en;
	logic [CMPS_NUM_PINS-1:0][1:0]            pad_lvl;
	wire logic [CMPS_NUM_PINS-1:0]            ahi;
	wire logic [CMPS_NUM_PINS-1:0]            blo;
	wire logic                                sclk;
	wire logic                                sdat;
	wire logic                                ssel_n;
	cmps_cfg_t                                cfg;
	logic                                     straps_valid;
	logic                                     serial_active;
	logic                                     regs_all_written;
	logic                                     first_write_ok;
	logic [CMPS_NUM_REGS-1:0][CMPS_DATA_W-1:0] user_regs;
	int                                       fails = 0;
	int                                       tests_run = 0;
	int                                       cyc = 0;
	logic [31:0]                              seed = 32'h0160e770;
	logic [7:0]                               corner [3] = '{8'h55, 8'h18, 8'h00};

	cmps_ctrl_pin_select #(.STABLE_CYCLES(STB)) u_cmps_ctrl_pin_select (.sys_clk(sys_clk), .arst_n(arst_n),
		.clk_en(clk_en), .serial_clk(sclk), .pin_above_hi(ahi), .pin_below_lo(blo), .serial_data_line(sdat),
		.serial_select_n(ssel_n), .cfg(cfg), .straps_valid(straps_valid), .serial_active(serial_active),
		.regs_all_written(regs_all_written), .first_write_ok(first_write_ok), .user_regs(user_regs));
	cmps_host_model u_cmps_host_model (.pad_lvl(pad_lvl), .pin_above_hi(ahi), .pin_below_lo(blo),
		.serial_clk(sclk), .serial_data_line(sdat), .serial_select_n(ssel_n));

	// ****************************************
	// Helpers
	// ****************************************
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// Hang guard, well above the eight hundred or so cycles the run needs
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 8000) begin
			fails++;
			give_verdict();
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Expected decode of the pads as they stand now
	function automatic cmps_cfg_t exp_cfg();
		cmps_cfg_t c;
		c = '0;
		c.extended_mode = (pad_lvl[CMPS_PIN_MODE] == CMPS_LVL_FLOAT);
		if (!c.extended_mode) begin
			c.range_high = (pad_lvl[CMPS_PIN_MODE] == CMPS_LVL_HIGH);
			c.swing_high = (pad_lvl[CMPS_PIN_SWING] == CMPS_LVL_HIGH);
			c.edge_pos = (pad_lvl[CMPS_PIN_EDGE] == CMPS_LVL_HIGH);
			c.ddr_mode = (pad_lvl[CMPS_PIN_EDGE] == CMPS_LVL_FLOAT);
			c.cal_delay_long = (pad_lvl[CMPS_PIN_CALIBRATION_DELAY_SELECT] == CMPS_LVL_HIGH);
		end
		return c;
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Pads change on the edge, then settle well past the filter
	task automatic set_pads(input logic [7:0] v);
		@(posedge sys_clk);
		pad_lvl <= v;
		repeat (14) @(posedge sys_clk);
		#1;
	endtask

	task automatic check_straps();
		cmps_cfg_t e;
		e = exp_cfg();
		check(16'(cfg), 16'(e));
		check(16'(serial_active), 16'(e.extended_mode));
		check(16'(straps_valid), 16'h0001);
	endtask

	// Ignored top nibble is random so stray bits there are exercised
	task automatic wr(input logic [3:0] a, input logic [15:0] d, input int n);
		logic [31:0] r;
		r = rnd();
		u_cmps_host_model.send({r[3:0], a, d}, n);
		repeat (10) @(posedge sys_clk);
		#1;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [15:0] d;
		pad_lvl = '0;
		clk_en = 1'b1;
		arst_n = 1'b0;
		repeat (8) @(posedge sys_clk);
		arst_n <= 1'b1;
		// Random straps, swing and delay pads always driven
		for (int i = 0; i < 16; i++) begin
			set_pads({2'(rnd() % 3), 2'(rnd() % 2), 2'(rnd() % 3), 2'(rnd() % 2)});
			check_straps();
		end
		foreach (corner[i]) begin
			set_pads(corner[i]);
			check_straps();
		end
		// One-cycle glitch and frozen clock enable must not move the setup
		@(posedge sys_clk);
		pad_lvl <= 8'h04;
		set_pads(8'h00);
		check_straps();
		@(posedge sys_clk);
		clk_en <= 1'b0;
		set_pads(8'h55);
		check(16'(cfg), 16'h0000);
		@(posedge sys_clk);
		clk_en <= 1'b1;
		repeat (14) @(posedge sys_clk);
		#1;
		check_straps();
		// Serial port is dead while the mode pad is driven
		wr(4'h1, 16'habcd, 24);
		check(user_regs[0], 16'h0000);
		set_pads(8'h80);
		check_straps();
		wr(CMPS_OFF_FIRST_WRITTEN_CONFIG, CMPS_FIRST_WRITTEN_DEFAULT, 24);
		check(user_regs[5], 16'h3fff);
		check(16'(first_write_ok), 16'h0001);
		wr(4'h1, 16'h1234, 20);
		wr(4'h4, 16'hffff, 24);
		check(user_regs[0], 16'h0000);
		// Remaining registers, completion only after the last
		for (int i = 0; i < CMPS_NUM_REGS; i++) begin
			if (i != 5) begin
				d = 16'(rnd());
				wr(CMPS_REG_OFF[i], d, 24);
				check(user_regs[i], d);
				check(16'(regs_all_written), 16'(i == 7));
			end
		end
		wr(CMPS_OFF_FIRST_WRITTEN_CONFIG, 16'h0001, 24);
		check(user_regs[5], 16'h0001);
		check(16'(first_write_ok), 16'h0001);
		// Reset in mid-run, then a wrong first value
		@(posedge sys_clk);
		arst_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		check(user_regs[5], 16'h0000);
		check(16'(cfg), 16'h0000);
		check(16'(regs_all_written), 16'h0000);
		@(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (14) @(posedge sys_clk);
		#1;
		check_straps();
		wr(CMPS_OFF_FIRST_WRITTEN_CONFIG, 16'h0fff, 24);
		check(user_regs[5], 16'h0fff);
		check(16'(first_write_ok), 16'h0000);
		// Verdict on the first write is kept once made
		wr(CMPS_OFF_FIRST_WRITTEN_CONFIG, CMPS_FIRST_WRITTEN_DEFAULT, 24);
		check(16'(first_write_ok), 16'h0000);
		give_verdict();
	end
endmodule
